// ==== rtl/mlic_pkg.sv ====
package mlic_pkg;

  // Vector and field widths, peripheral base table size
  localparam int VEC_W      = 14;
  localparam int OFS_W      = 8;
  localparam int PSEL_W     = 2;
  localparam int PERIPH_MAX = 4;
  localparam int ADDR_W     = 12;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS     = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS   = 12'h004;
  localparam logic [ADDR_W-1:0] RR_PTR_OFS   = 12'h008;
  localparam logic [ADDR_W-1:0] BASE_OFS     = 12'h010;
  localparam logic [ADDR_W-1:0] SRC_CFG_OFS  = 12'h040;

  // Control register bits
  localparam int CTRL_LOW_EN_BIT = 0;
  localparam int CTRL_MED_EN_BIT = 1;
  localparam int CTRL_HI_EN_BIT  = 2;
  localparam int CTRL_RR_EN_BIT  = 6;
  localparam int CTRL_BOOT_BIT   = 7;

  // Status register bits
  localparam int STAT_LOW_BIT = 0;
  localparam int STAT_MED_BIT = 1;
  localparam int STAT_HI_BIT  = 2;
  localparam int STAT_NMI_BIT = 7;

  // Source configuration field positions
  localparam int CFG_EN_BIT    = 0;
  localparam int CFG_LVL_LSB   = 1;
  localparam int CFG_OFS_LSB   = 8;
  localparam int CFG_PSEL_LSB  = 16;

  // Level codes
  localparam logic [1:0] LVL_OFF  = 2'h0;
  localparam logic [1:0] LVL_LOW  = 2'h1;
  localparam logic [1:0] LVL_MED  = 2'h2;
  localparam logic [1:0] LVL_HIGH = 2'h3;

  // Reset values and vector table constants
  localparam logic [7:0]       CTRL_RST   = 8'h00;
  localparam logic [VEC_W-1:0] VEC_RST    = 14'h0000;
  localparam logic [VEC_W-1:0] BOOT_BASE  = 14'h1000;
  localparam logic [VEC_W-1:0] NMI_OFFSET = 14'h0002;

  typedef struct packed {
    logic [PSEL_W-1:0] periph;
    logic [OFS_W-1:0]  offset;
    logic [1:0]        level;
    logic              enable;
  } src_cfg_s;

  typedef struct packed {
    logic boot_sel;
    logic rr_en;
    logic hi_en;
    logic med_en;
    logic low_en;
  } ctrl_s;

  typedef struct packed {
    logic nmi;
    logic hi;
    logic med;
    logic low;
  } active_s;

endpackage : mlic_pkg

// ==== rtl/multilevel_irq_controller.sv ====
// Behaviour
// - Each source has own enable, config, vector
// - Request held while source condition present
// - Acknowledge loads program counter with vector
// - Each source picks low, medium or high
// - Medium pre-empts running low handler
// - High pre-empts medium and low handlers
// - Same level: lowest vector address wins
// - Optional round-robin among low-level requests
// - Non-maskable request ignores level enables
// - Vector is peripheral base plus offset
// - Vectors given in program words
// - Vector table in application or boot area
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps

module multilevel_irq_controller #(
  parameter int NUM_SRC = 16
) (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst,
  input  wire logic                       i_psel,
  input  wire logic                       i_penable,
  input  wire logic                       i_pwrite,
  input  wire logic [31:0]                i_paddr,
  input  wire logic [31:0]                i_pwdata,
  output logic      [31:0]                o_prdata,
  output logic                            o_pready,
  output logic                            o_pslverr,
  input  wire logic [NUM_SRC-1:0]         i_irq_src,
  input  wire logic                       i_nmi,
  input  wire logic                       i_core_ready,
  input  wire logic                       i_reti,
  output logic                            o_pc_load,
  output logic      [mlic_pkg::VEC_W-1:0] o_pc_vector,
  output logic                            o_irq_pending,
  output mlic_pkg::active_s               o_active
);

  localparam int IDX_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;
  localparam int VW    = mlic_pkg::VEC_W;

  mlic_pkg::ctrl_s    ctrl;
  mlic_pkg::active_s  active;
  mlic_pkg::active_s  next_active;
  mlic_pkg::src_cfg_s cfg [NUM_SRC];
  logic [VW-1:0]      periph_base [mlic_pkg::PERIPH_MAX];
  logic [VW-1:0]      rr_ptr;

  logic [NUM_SRC-1:0][VW-1:0] vec;
  logic [NUM_SRC-1:0]         req_low;
  logic [NUM_SRC-1:0]         req_med;
  logic [NUM_SRC-1:0]         req_hi;
  logic [IDX_W:0]             pick_hi;
  logic [IDX_W:0]             pick_med;
  logic [IDX_W:0]             pick_low_fix;
  logic [IDX_W:0]             pick_low_rr;
  logic [IDX_W:0]             pick_low;
  logic                       grant;
  logic [VW-1:0]              grant_vec;
  mlic_pkg::active_s          grant_lvl;
  logic [VW-1:0]              table_base;
  logic [VW-1:0]              nmi_vec;

  // Lowest vector among masked sources, optionally above a floor
  function automatic logic [IDX_W:0] pick_min(
    input logic [NUM_SRC-1:0]         mask,
    input logic [NUM_SRC-1:0][VW-1:0] v,
    input logic                       use_floor,
    input logic [VW-1:0]              floor_v
  );
    logic           found;
    logic [IDX_W-1:0] idx;
    logic [VW-1:0]  best;
    found = 1'b0;
    idx   = '0;
    best  = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (mask[i] && (!use_floor || v[i] > floor_v) &&
          (!found || v[i] < best)) begin
        found = 1'b1;
        idx   = IDX_W'(i);
        best  = v[i];
      end
    end
    return {found, idx};
  endfunction : pick_min

  // Address decode helpers
  function automatic logic in_range(
    input logic [31:0] addr,
    input logic [mlic_pkg::ADDR_W-1:0] base,
    input int count
  );
    logic [31:0] rel;
    rel = addr - {20'h00000, base};
    return (addr >= {20'h00000, base}) && (rel[31:2] < 30'(count)) &&
           (rel[1:0] == 2'h0);
  endfunction : in_range

  function automatic logic [IDX_W-1:0] word_idx(
    input logic [31:0] addr,
    input logic [mlic_pkg::ADDR_W-1:0] base
  );
    logic [31:0] rel;
    rel = addr - {20'h00000, base};
    return rel[IDX_W+1:2];
  endfunction : word_idx

  // Vector formation
  always_comb begin
    table_base = ctrl.boot_sel ? mlic_pkg::BOOT_BASE : mlic_pkg::VEC_RST;
    nmi_vec    = table_base + mlic_pkg::NMI_OFFSET;
    for (int i = 0; i < NUM_SRC; i++) begin
      // Word units throughout; no byte scaling applied
      vec[i] = table_base + periph_base[cfg[i].periph] +
               VW'(cfg[i].offset);
    end
  end

  // Per level request masks
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      // Level sensitive: asserted while the source holds its line
      req_low[i] = i_irq_src[i] && cfg[i].enable && ctrl.low_en &&
                   cfg[i].level == mlic_pkg::LVL_LOW;
      req_med[i] = i_irq_src[i] && cfg[i].enable && ctrl.med_en &&
                   cfg[i].level == mlic_pkg::LVL_MED;
      req_hi[i]  = i_irq_src[i] && cfg[i].enable && ctrl.hi_en &&
                   cfg[i].level == mlic_pkg::LVL_HIGH;
    end
  end

  // Arbitration within each level
  always_comb begin
    pick_hi      = pick_min(req_hi, vec, 1'b0, rr_ptr);
    pick_med     = pick_min(req_med, vec, 1'b0, rr_ptr);
    pick_low_fix = pick_min(req_low, vec, 1'b0, rr_ptr);
    pick_low_rr  = pick_min(req_low, vec, 1'b1, rr_ptr);
    // Wrap to the lowest vector once nothing lies above the pointer
    if (ctrl.rr_en && pick_low_rr[IDX_W]) begin
      pick_low = pick_low_rr;
    end else begin
      pick_low = pick_low_fix;
    end
  end

  // Level selection against handlers in progress
  always_comb begin
    grant     = 1'b0;
    grant_vec = nmi_vec;
    grant_lvl = '0;
    if (i_nmi && !active.nmi) begin
      grant         = 1'b1;
      grant_lvl.nmi = 1'b1;
    end else if (pick_hi[IDX_W] && !active.nmi && !active.hi) begin
      grant        = 1'b1;
      grant_vec    = vec[pick_hi[IDX_W-1:0]];
      grant_lvl.hi = 1'b1;
    end else if (pick_med[IDX_W] && !active.nmi && !active.hi &&
                 !active.med) begin
      grant         = 1'b1;
      grant_vec     = vec[pick_med[IDX_W-1:0]];
      grant_lvl.med = 1'b1;
    end else if (pick_low[IDX_W] && !active.nmi && !active.hi &&
                 !active.med && !active.low) begin
      grant         = 1'b1;
      grant_vec     = vec[pick_low[IDX_W-1:0]];
      grant_lvl.low = 1'b1;
    end
  end

  // Program counter steering
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_pc_load   <= 1'b0;
      o_pc_vector <= mlic_pkg::VEC_RST;
    end else begin
      o_pc_load <= grant && i_core_ready;
      if (grant && i_core_ready) begin
        o_pc_vector <= grant_vec;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_irq_pending <= 1'b0;
    end else begin
      o_irq_pending <= grant;
    end
  end

  // Active levels: return clears the top one, a new grant still wins
  always_comb begin
    next_active = active;
    if (i_reti) begin
      if (active.nmi) begin
        next_active.nmi = 1'b0;
      end else if (active.hi) begin
        next_active.hi = 1'b0;
      end else if (active.med) begin
        next_active.med = 1'b0;
      end else begin
        next_active.low = 1'b0;
      end
    end
    if (grant && i_core_ready) begin
      next_active = next_active | grant_lvl;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      active <= '0;
    end else begin
      active <= next_active;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_active <= '0;
    end else begin
      o_active <= active;
    end
  end

  // APB: ready in the first access cycle, no wait states
  logic apb_setup;
  logic apb_write;
  logic rd_hit;
  logic [31:0] rd_val;

  assign apb_setup = i_psel && !i_penable;
  assign apb_write = i_psel && i_penable && o_pready && i_pwrite;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (i_paddr == {20'h00000, mlic_pkg::CTRL_OFS}) begin
      rd_val[mlic_pkg::CTRL_LOW_EN_BIT] = ctrl.low_en;
      rd_val[mlic_pkg::CTRL_MED_EN_BIT] = ctrl.med_en;
      rd_val[mlic_pkg::CTRL_HI_EN_BIT]  = ctrl.hi_en;
      rd_val[mlic_pkg::CTRL_RR_EN_BIT]  = ctrl.rr_en;
      rd_val[mlic_pkg::CTRL_BOOT_BIT]   = ctrl.boot_sel;
    end else if (i_paddr == {20'h00000, mlic_pkg::STATUS_OFS}) begin
      rd_val[mlic_pkg::STAT_LOW_BIT] = active.low;
      rd_val[mlic_pkg::STAT_MED_BIT] = active.med;
      rd_val[mlic_pkg::STAT_HI_BIT]  = active.hi;
      rd_val[mlic_pkg::STAT_NMI_BIT] = active.nmi;
    end else if (i_paddr == {20'h00000, mlic_pkg::RR_PTR_OFS}) begin
      rd_val[VW-1:0] = rr_ptr;
    end else if (in_range(i_paddr, mlic_pkg::BASE_OFS,
                          mlic_pkg::PERIPH_MAX)) begin
      rd_val[VW-1:0] = periph_base[i_paddr[3:2]];
    end else if (in_range(i_paddr, mlic_pkg::SRC_CFG_OFS, NUM_SRC)) begin
      rd_val[mlic_pkg::CFG_PSEL_LSB +: mlic_pkg::PSEL_W] =
        cfg[word_idx(i_paddr, mlic_pkg::SRC_CFG_OFS)].periph;
      rd_val[mlic_pkg::CFG_OFS_LSB +: mlic_pkg::OFS_W] =
        cfg[word_idx(i_paddr, mlic_pkg::SRC_CFG_OFS)].offset;
      rd_val[mlic_pkg::CFG_LVL_LSB +: 2] =
        cfg[word_idx(i_paddr, mlic_pkg::SRC_CFG_OFS)].level;
      rd_val[mlic_pkg::CFG_EN_BIT] =
        cfg[word_idx(i_paddr, mlic_pkg::SRC_CFG_OFS)].enable;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready <= apb_setup;
      if (apb_setup) begin
        o_pslverr <= !rd_hit;
        o_prdata  <= (rd_hit && !i_pwrite) ? rd_val : 32'h0000_0000;
      end else begin
        o_pslverr <= 1'b0;
        o_prdata  <= 32'h0000_0000;
      end
    end
  end

  // Control register
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl <= '0;
    end else if (apb_write &&
                 i_paddr == {20'h00000, mlic_pkg::CTRL_OFS}) begin
      ctrl.low_en   <= i_pwdata[mlic_pkg::CTRL_LOW_EN_BIT];
      ctrl.med_en   <= i_pwdata[mlic_pkg::CTRL_MED_EN_BIT];
      ctrl.hi_en    <= i_pwdata[mlic_pkg::CTRL_HI_EN_BIT];
      ctrl.rr_en    <= i_pwdata[mlic_pkg::CTRL_RR_EN_BIT];
      ctrl.boot_sel <= i_pwdata[mlic_pkg::CTRL_BOOT_BIT];
    end
  end

  // Round-robin pointer follows each low-level acceptance
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rr_ptr <= mlic_pkg::VEC_RST;
    end else if (grant && i_core_ready && grant_lvl.low) begin
      rr_ptr <= grant_vec;
    end else if (apb_write &&
                 i_paddr == {20'h00000, mlic_pkg::RR_PTR_OFS}) begin
      rr_ptr <= i_pwdata[VW-1:0];
    end
  end

  // Peripheral base table
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      for (int p = 0; p < mlic_pkg::PERIPH_MAX; p++) begin
        periph_base[p] <= mlic_pkg::VEC_RST;
      end
    end else if (apb_write && in_range(i_paddr, mlic_pkg::BASE_OFS,
                                       mlic_pkg::PERIPH_MAX)) begin
      periph_base[i_paddr[3:2]] <= i_pwdata[VW-1:0];
    end
  end

  // Source configuration
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        cfg[i] <= '0;
      end
    end else if (apb_write &&
                 in_range(i_paddr, mlic_pkg::SRC_CFG_OFS, NUM_SRC)) begin
      cfg[word_idx(i_paddr, mlic_pkg::SRC_CFG_OFS)] <= '{
        periph: i_pwdata[mlic_pkg::CFG_PSEL_LSB +: mlic_pkg::PSEL_W],
        offset: i_pwdata[mlic_pkg::CFG_OFS_LSB +: mlic_pkg::OFS_W],
        level:  i_pwdata[mlic_pkg::CFG_LVL_LSB +: 2],
        enable: i_pwdata[mlic_pkg::CFG_EN_BIT]
      };
    end
  end

endmodule : multilevel_irq_controller

// ==== test/mlic_properties.sv ====
`timescale 1ns/1ps
module mlic_properties #(
  parameter int NUM_SRC = 16
) (
  input wire logic                       i_clk_sys,
  input wire logic                       i_rst,
  input wire logic                       i_core_ready,
  input wire logic                       i_reti,
  input wire logic                       i_nmi,
  input wire logic [NUM_SRC-1:0]         i_irq_src,
  input wire logic                       o_pready,
  input wire logic                       o_pslverr,
  input wire logic [31:0]                o_prdata,
  input wire logic                       o_pc_load,
  input wire logic [mlic_pkg::VEC_W-1:0] o_pc_vector,
  input wire logic                       o_irq_pending,
  input wire mlic_pkg::active_s          o_active
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Quiet return: no fresh request may refill the low level
  sequence s_ret_low;
    i_reti && o_active == 4'h1 && !o_pc_load && i_irq_src == '0 && !i_nmi;
  endsequence
  sequence s_nmi_ask;
    i_nmi && i_core_ready && !o_active.nmi && !o_pc_load;
  endsequence
  a_load_ready: assert property (o_pc_load |-> $past(i_core_ready))
    else $error("vector load without core ready");
  a_vec_hold: assert property (!o_pc_load |-> $stable(o_pc_vector))
    else $error("vector changed without load");
  a_load_pend: assert property (o_pc_load |-> o_irq_pending)
    else $error("load without pending request");
  a_act_follow: assert property (o_pc_load |=> o_active != 4'h0)
    else $error("no active level after load");
  a_med_preempt: assert property ($rose(o_active.med) |->
    !o_active.hi && !o_active.nmi) else $error("medium over higher level");
  a_hi_preempt: assert property ($rose(o_active.hi) |->
    !o_active.nmi) else $error("high granted over nmi");
  a_ret_low: assert property (s_ret_low |=> ##1 !o_active.low)
    else $error("low level not cleared by return");
  a_nmi_take: assert property (s_nmi_ask |=> o_pc_load)
    else $error("nmi not taken");
  a_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("slave error without ready");
  a_rd_idle: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside access");
endmodule : mlic_properties

// ==== test/core_model.sv ====
`timescale 1ns/1ps
module core_model (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_pc_load,
  input  wire logic i_ret_req,
  input  wire logic i_slow,
  output logic      o_core_ready,
  output logic      o_reti
);
  logic [1:0] cnt;
  // Core busy one cycle after each load, as it refetches
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt          <= 2'h0;
      o_core_ready <= 1'b0;
      o_reti       <= 1'b0;
    end else begin
      cnt          <= cnt + 2'h1;
      o_core_ready <= !i_pc_load && (!i_slow || cnt == 2'h3);
      o_reti       <= i_ret_req;
    end
  end
endmodule : core_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  localparam int NS = 4;
  logic                       i_clk_sys, i_rst, i_psel, i_penable, i_pwrite;
  logic                       i_nmi, i_core_ready, i_reti, o_pc_load;
  logic                       o_pready, o_pslverr, o_irq_pending;
  logic                       ret_req, slow, rerr;
  logic [31:0]                i_paddr, i_pwdata, o_prdata, rdat;
  logic [NS-1:0]              i_irq_src;
  logic [mlic_pkg::VEC_W-1:0] o_pc_vector;
  mlic_pkg::active_s          o_active;
  int                         n_mismatch, n_compared, seed, tbl, act, b, ptr;
  int                         lv[NS], ofs[NS], ps[NS], bs[4];

  multilevel_irq_controller #(.NUM_SRC(NS)) multilevel_irq_controller_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_irq_src(i_irq_src), .i_nmi(i_nmi),
    .i_core_ready(i_core_ready), .i_reti(i_reti), .o_pc_load(o_pc_load),
    .o_pc_vector(o_pc_vector), .o_irq_pending(o_irq_pending),
    .o_active(o_active));
  core_model core_model_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_pc_load(o_pc_load), .i_ret_req(ret_req), .i_slow(slow),
    .o_core_ready(i_core_ready), .o_reti(i_reti));

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  task end_of_test;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  task check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Ready and data are taken at the rising edge where the answer stands
  task apb(input logic w, input logic [31:0] a, d);
    int n;
    @(posedge i_clk_sys);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_clk_sys) i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      n_mismatch++;
      end_of_test;
    end
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task wr(input logic [31:0] a, d);
    apb(1'b1, a, d);
    check("write error", rerr, 0);
  endtask : wr

  task rd(input logic [31:0] a, exp, e);
    apb(1'b0, a, 0);
    check("read data", rdat, exp);
    check("read error", rerr, e);
  endtask : rd

  function int vec(int s);
    return (tbl + bs[ps[s]] + ofs[s]) & 32'h3FFF;
  endfunction : vec

  function int pick(int l);
    int r;
    r = -1;
    for (int s = 0; s < NS; s++) begin
      if (i_irq_src[s] && lv[s] == l && (r < 0 || vec(s) < vec(r))) r = s;
    end
    return r;
  endfunction : pick

  task setcfg(int s, int l, int o, int p);
    lv[s]  = l;
    ofs[s] = o & 32'hFF;
    ps[s]  = p & 32'h3;
    wr(mlic_pkg::SRC_CFG_OFS + 4 * s, 1 | l << 1 | ofs[s] << 8 | ps[s] << 16);
  endtask : setcfg

  task expect_load(int v, int l);
    int n;
    n = 0;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while (o_pc_load !== 1'b1 && n < 40);
    if (o_pc_load !== 1'b1) begin
      n_mismatch++;
      end_of_test;
    end
    check("pc vector", o_pc_vector, v);
    check("pending", o_irq_pending, 1);
    act = act | (1 << (l - 1));
    @(negedge i_clk_sys);
    check("active", o_active, act);
  endtask : expect_load

  task ret;
    @(posedge i_clk_sys) ret_req <= 1'b1;
    @(posedge i_clk_sys) ret_req <= 1'b0;
    for (int k = 3; k >= 0; k--) begin
      if (act[k]) begin
        act[k] = 0;
        break;
      end
    end
  endtask : ret

  task quiet(int n);
    repeat (n) begin
      @(negedge i_clk_sys);
      check("no load", o_pc_load, 0);
      check("no pending", o_irq_pending, 0);
    end
  endtask : quiet

  initial begin
    seed = 32'h937E4C19;
    {i_rst, i_psel, i_penable, i_pwrite, i_nmi, ret_req, slow} = 7'h41;
    {i_paddr, i_pwdata, i_irq_src, tbl, act} = '0;
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd(mlic_pkg::CTRL_OFS, 0, 0);
    rd(mlic_pkg::STATUS_OFS, 0, 0);
    rd(32'h100, 0, 1);
    for (int p = 0; p < 4; p++) begin
      bs[p] = $random(seed) & 32'h3FF;
      wr(mlic_pkg::BASE_OFS + 4 * p, bs[p]);
      rd(mlic_pkg::BASE_OFS + 4 * p, bs[p], 0);
    end
    wr(mlic_pkg::CTRL_OFS, 32'h7);
    for (int l = 1; l <= 3; l++) begin
      slow <= l[0];
      for (int s = 0; s < NS; s++) setcfg(s, l, $random(seed), $random(seed));
      @(posedge i_clk_sys) i_irq_src <= '1;
      @(negedge i_clk_sys);
      repeat (NS) begin
        b = pick(l);
        expect_load(vec(b), l);
        @(posedge i_clk_sys) i_irq_src[b] <= 1'b0;
        ret;
      end
    end
    for (int s = 0; s < NS; s++) setcfg(s, s + 1, $random(seed), s);
    for (int s = 0; s < 3; s++) begin
      @(posedge i_clk_sys) i_irq_src[s] <= 1'b1;
      expect_load(vec(s), s + 1);
      @(posedge i_clk_sys) i_irq_src[s] <= 1'b0;
    end
    setcfg(3, 0, 0, 0);
    @(posedge i_clk_sys) i_irq_src <= 4'h9;
    quiet(10);
    @(posedge i_clk_sys) i_irq_src <= 4'h8;
    repeat (3) ret;
    quiet(6);
    check("active", o_active, act);
    @(posedge i_clk_sys) i_irq_src <= 4'h1;
    expect_load(vec(0), 1);
    @(posedge i_clk_sys) i_irq_src <= 4'h0;
    ret;
    wr(mlic_pkg::CTRL_OFS, 0);
    @(posedge i_clk_sys) i_nmi <= 1'b1;
    i_irq_src <= 4'h1;
    expect_load(tbl + mlic_pkg::NMI_OFFSET, 4);
    @(posedge i_clk_sys) i_nmi <= 1'b0;
    ret;
    quiet(8);
    @(posedge i_clk_sys) i_irq_src <= '0;
    wr(mlic_pkg::CTRL_OFS, 32'hC1);
    tbl = 32'h1000;
    rd(mlic_pkg::CTRL_OFS, 32'hC1, 0);
    for (int s = 0; s < NS; s++) setcfg(s, 1, s * 8 + 1, 0);
    ptr = vec(2);
    wr(mlic_pkg::RR_PTR_OFS, ptr);
    @(posedge i_clk_sys) i_irq_src <= '1;
    for (int k = 0; k < 6; k++) begin
      b = (k + 3) % NS;
      expect_load(vec(b), 1);
      ptr = vec(b);
      ret;
    end
    @(posedge i_clk_sys) i_irq_src <= '0;
    rd(mlic_pkg::RR_PTR_OFS, ptr, 0);
    end_of_test;
  end
endmodule : tb_top

bind multilevel_irq_controller mlic_properties #(.NUM_SRC(NUM_SRC))
  mlic_properties_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
  .i_core_ready(i_core_ready), .i_reti(i_reti), .i_nmi(i_nmi),
  .i_irq_src(i_irq_src), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_prdata(o_prdata), .o_pc_load(o_pc_load), .o_pc_vector(o_pc_vector),
  .o_irq_pending(o_irq_pending), .o_active(o_active));
